// [common/tpir_pkg.sv]
// constants and types of the touch panel register bank
package tpir_pkg;
  localparam logic [6:0] DEV_ADDR       = 7'h51;
  localparam logic [7:0] ADDR_BYTE_READ  = 8'hA2;
  localparam logic [7:0] ADDR_BYTE_WRITE = 8'hA3;
  localparam logic [7:0] IDX_CFG   = 8'h00;
  localparam logic [7:0] IDX_Y_LO  = 8'h08;
  localparam logic [7:0] IDX_Y_HI  = 8'h09;
  localparam logic [7:0] IDX_X_LO  = 8'h0A;
  localparam logic [7:0] IDX_X_HI  = 8'h0B;
  localparam logic [7:0] IDX_EVT   = 8'h0C;
  localparam logic [7:0] CFG_RESET = 8'h01;
  localparam int         CFG_SCAN_BIT = 0;
  localparam logic [3:0] EVT_NONE   = 4'h0;
  localparam logic [3:0] EVT_DOWN   = 4'h1;
  localparam logic [3:0] EVT_REPEAT = 4'h2;
  localparam logic [3:0] EVT_UP     = 4'h3;
  localparam logic [9:0] NO_PRESS_LIMIT = 10'h3A0;
  localparam int CLK_HZ        = 50_000_000;
  localparam int REPEAT_HZ     = 20;
  localparam int REPEAT_CYCLES = CLK_HZ / REPEAT_HZ;
  localparam int REP_W         = 22;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    TPIR_IDLE     = 3'h0,
    TPIR_ADDR     = 3'h1,
    TPIR_ADDR_ACK = 3'h3,
    TPIR_RX       = 3'h2,
    TPIR_RX_ACK   = 3'h6,
    TPIR_TX       = 3'h7,
    TPIR_TX_ACK   = 3'h5
  } tpir_bus_st_t;

  typedef struct packed {
    logic       valid;
    logic [9:0] x;
    logic [9:0] y;
  } tpir_meas_t;

  typedef struct packed {
    logic             scl_s1;
    logic             scl_s2;
    logic             scl_s3;
    logic             sda_s1;
    logic             sda_s2;
    logic             sda_s3;
    tpir_bus_st_t     st;
    logic [3:0]       bit_cnt;
    logic [7:0]       shift;
    logic             rw_read;
    logic             first;
    logic             nack;
    logic [7:0]       index;
    logic             sda_oe;
    logic [7:0]       cfg;
    logic [9:0]       x;
    logic [9:0]       y;
    logic             pen_down;
    logic [REP_W-1:0] rep_cnt;
    logic [3:0]       evt;
  } tpir_state_t;
endpackage

// [tb/tpir_host.sv]
// i2c host model that drives the panel controller's bus
`timescale 1ns/1ps
module tpir_host (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  localparam int HALF = 80;

  // idle bus: clock high and data released to its pull-up
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // data moves only while the clock is low
  task automatic bit_out(input logic b);
    #(HALF / 2) sda_pull = ~b;
    #(HALF / 2) scl = 1'b1;
    #HALF scl = 1'b0;
  endtask

  task automatic bit_in(output logic b);
    #(HALF / 2) sda_pull = 1'b0;
    #(HALF / 2) scl = 1'b1;
    b = sda;
    #HALF scl = 1'b0;
  endtask

  // also serves as a repeated start
  task automatic start();
    #(HALF / 2) sda_pull = 1'b0;
    #(HALF / 2) scl = 1'b1;
    #HALF sda_pull = 1'b1;
    #HALF scl = 1'b0;
  endtask

  task automatic stop();
    #(HALF / 2) sda_pull = 1'b1;
    #(HALF / 2) scl = 1'b1;
    #HALF sda_pull = 1'b0;
    #HALF;
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = ~a;
  endtask

  // a high bit after the last byte tells the device to stop sending
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_in(b);
      d[i] = b;
    end
    bit_out(last);
  endtask
endmodule // tpir_host

// [tb/tpir_regs_tb_top.sv]
// self-checking bench of the touch panel register bank
`timescale 1ns/1ps
module tpir_regs_tb_top;
  localparam int REP = 2000;
  logic                 clk;
  logic                 srst;
  logic                 scl;
  logic                 host_pull;
  wire                  sda;
  logic                 sda_o;
  logic                 sda_oe;
  logic                 scan_en;
  logic                 irq;
  tpir_pkg::tpir_meas_t meas;
  int                   error_cnt;
  int                   comparisons;
  int                   cycles;
  int                   t0;
  logic [9:0]           cx;
  logic [9:0]           cy;
  logic [7:0]           rd [5];
  logic                 ack;

  // open drain with a pull-up: low while either side pulls
  assign sda = ~(host_pull | sda_oe);

  tpir_regs #(.REPEAT_CYCLES(REP)) i_dut (
    .clk     (clk),
    .srst    (srst),
    .scl_i   (scl),
    .sda_i   (sda),
    .sda_o   (sda_o),
    .sda_oe  (sda_oe),
    .meas    (meas),
    .scan_en (scan_en),
    .irq     (irq)
  );

  tpir_host i_host (
    .scl      (scl),
    .sda_pull (host_pull),
    .sda      (sda)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic give_verdict();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] exp_reg(input logic [7:0] idx, input logic [3:0] ev);
    case (idx)
      tpir_pkg::IDX_Y_LO: return cy[7:0];
      tpir_pkg::IDX_Y_HI: return {6'h00, cy[9:8]};
      tpir_pkg::IDX_X_LO: return cx[7:0];
      tpir_pkg::IDX_X_HI: return {6'h00, cx[9:8]};
      tpir_pkg::IDX_EVT:  return {4'h0, ev};
      default:            return 8'h00;
    endcase
  endfunction

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    logic a;
    i_host.start();
    i_host.put_byte(tpir_pkg::ADDR_BYTE_WRITE, a);
    chk(a, 1'b1);
    i_host.put_byte(idx, a);
    i_host.put_byte(d, a);
    i_host.stop();
  endtask

  task automatic rd_regs(input logic [7:0] idx, input int n);
    logic a;
    i_host.start();
    i_host.put_byte(tpir_pkg::ADDR_BYTE_WRITE, a);
    i_host.put_byte(idx, a);
    i_host.stop();
    i_host.start();
    i_host.put_byte(tpir_pkg::ADDR_BYTE_READ, a);
    chk(a, 1'b1);
    for (int i = 0; i < n; i++) i_host.get_byte(i == n - 1, rd[i]);
    i_host.stop();
  endtask

  // burst over the coordinate and event registers
  task automatic check_all(input logic [3:0] ev);
    rd_regs(tpir_pkg::IDX_Y_LO, 5);
    for (int i = 0; i < 5; i++) chk(rd[i], exp_reg(8'h08 + 8'(i), ev));
  endtask

  task automatic give_meas(input logic [9:0] x, input logic [9:0] y);
    @(negedge clk);
    meas = '{1'b1, x, y};
    @(negedge clk);
    meas.valid = 1'b0;
    @(negedge clk);
  endtask

  initial begin
    error_cnt   = 0;
    comparisons = 0;
    cycles      = 0;
    srst        = 1'b1;
    meas        = '0;
    cx          = 10'h000;
    cy          = 10'h000;
    void'($urandom(32'h2C64));
    repeat (10) @(posedge clk);
    @(negedge clk) srst = 1'b0;
    repeat (3) @(negedge clk);
    chk(scan_en, 1'b1);
    chk(irq, 1'b0);
    chk(sda_o, 1'b0);
    rd_regs(tpir_pkg::IDX_CFG, 1);
    chk(rd[0], tpir_pkg::CFG_RESET);
    check_all(tpir_pkg::EVT_NONE);
    i_host.start();
    i_host.put_byte({7'h52, 1'b1}, ack);
    i_host.stop();
    chk(ack, 1'b0);
    for (int k = 0; k < 3; k++) begin
      cx = (k == 0) ? tpir_pkg::NO_PRESS_LIMIT : 10'($urandom_range(32'h3A0));
      cy = (k == 0) ? tpir_pkg::NO_PRESS_LIMIT : 10'($urandom_range(32'h3A0));
      t0 = cycles;
      give_meas(cx, cy);
      chk(irq, 1'b1);
      check_all(tpir_pkg::EVT_DOWN);
      chk(irq, 1'b0);
      while (irq !== 1'b1 && cycles - t0 < 2 * REP) @(negedge clk);
      chk(cycles - t0 >= REP - 4 && cycles - t0 <= REP + 4, 1'b1);
      rd_regs(tpir_pkg::IDX_EVT, 1);
      chk(rd[0], {4'h0, tpir_pkg::EVT_REPEAT});
      give_meas(10'h3A1, 10'($urandom_range(32'h3A0)));
      chk(irq, 1'b1);
      check_all(tpir_pkg::EVT_UP);
    end
    wr_reg(tpir_pkg::IDX_CFG, 8'h00);
    chk(scan_en, 1'b0);
    give_meas(10'h100, 10'h100);
    chk(irq, 1'b0);
    wr_reg(tpir_pkg::IDX_X_LO, 8'hFF);
    wr_reg(tpir_pkg::IDX_CFG, 8'h01);
    chk(scan_en, 1'b1);
    rd_regs(tpir_pkg::IDX_CFG, 1);
    chk(rd[0], 8'h01);
    check_all(tpir_pkg::EVT_NONE);
    rd_regs(8'h05, 1);
    chk(rd[0], 8'h00);
    // reset in mid-run brings every register back to its reset value
    cx = 10'($urandom_range(32'h3A0));
    cy = 10'($urandom_range(32'h3A0));
    give_meas(cx, cy);
    chk(irq, 1'b1);
    wr_reg(tpir_pkg::IDX_CFG, 8'h00);
    chk(scan_en, 1'b0);
    @(negedge clk) srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk(scan_en, 1'b1);
    chk(irq, 1'b0);
    cx = 10'h000;
    cy = 10'h000;
    rd_regs(tpir_pkg::IDX_CFG, 1);
    chk(rd[0], tpir_pkg::CFG_RESET);
    check_all(tpir_pkg::EVT_NONE);
    give_verdict();
  end
endmodule // tpir_regs_tb_top

// [verilog/tpir_regs.sv]
// i2c slave register bank of a resistive touch panel controller
`timescale 1ns/1ps
module tpir_regs #(
  parameter int REPEAT_CYCLES = tpir_pkg::REPEAT_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  input  wire tpir_pkg::tpir_meas_t meas,
  output logic                      scan_en,
  output logic                      irq
);
  tpir_pkg::tpir_state_t q;
  tpir_pkg::tpir_state_t d;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  bus_start;
  logic                  bus_stop;
  logic                  press;
  logic                  meas_take;
  logic                  addr_done;
  logic                  rx_done;
  logic [3:0]            new_evt;
  logic                  evt_clr;
  logic [7:0]            rd_byte;

  // last count of the repeat period, cut to the counter width
  localparam int                         REP_LAST_I = REPEAT_CYCLES - 1;
  localparam logic [tpir_pkg::REP_W-1:0] REP_LAST   = REP_LAST_I[tpir_pkg::REP_W-1:0];

  function automatic logic [7:0] reg_read(input logic [7:0] idx,
                                          input tpir_pkg::tpir_state_t s);
    logic [7:0] r;
    r = 8'h00;
    if (idx == tpir_pkg::IDX_CFG) begin
      r = s.cfg;
    end else if (idx == tpir_pkg::IDX_Y_LO) begin
      r = s.y[7:0];
    end else if (idx == tpir_pkg::IDX_Y_HI) begin
      r = {6'h00, s.y[9:8]};
    end else if (idx == tpir_pkg::IDX_X_LO) begin
      r = s.x[7:0];
    end else if (idx == tpir_pkg::IDX_X_HI) begin
      r = {6'h00, s.x[9:8]};
    end else if (idx == tpir_pkg::IDX_EVT) begin
      r = {4'h0, s.evt};
    end
    return r;
  endfunction

  // edges and bus conditions look only at the second and third sync stages
  assign scl_rise  = q.scl_s2 & ~q.scl_s3;
  assign scl_fall  = ~q.scl_s2 & q.scl_s3;
  assign bus_start = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
  assign bus_stop  = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
  assign addr_done = (q.st == tpir_pkg::TPIR_ADDR) && scl_fall
                     && (q.bit_cnt == tpir_pkg::BITS_PER_BYTE);
  assign rx_done   = (q.st == tpir_pkg::TPIR_RX) && scl_fall
                     && (q.bit_cnt == tpir_pkg::BITS_PER_BYTE);
  assign press     = (meas.x <= tpir_pkg::NO_PRESS_LIMIT)
                     && (meas.y <= tpir_pkg::NO_PRESS_LIMIT);
  assign meas_take = meas.valid && q.cfg[tpir_pkg::CFG_SCAN_BIT];
  // byte that a read loads at the current index
  assign rd_byte   = reg_read(q.index, q);

  always_comb begin
    d         = q;
    evt_clr   = 1'b0;
    new_evt   = tpir_pkg::EVT_NONE;
    d.scl_s1  = scl_i;
    d.scl_s2  = q.scl_s1;
    d.scl_s3  = q.scl_s2;
    d.sda_s1  = sda_i;
    d.sda_s2  = q.sda_s1;
    d.sda_s3  = q.sda_s2;
    if (bus_start) begin
      d.st      = tpir_pkg::TPIR_ADDR;
      d.bit_cnt = 4'h0;
      d.sda_oe  = 1'b0;
    end else if (bus_stop) begin
      d.st      = tpir_pkg::TPIR_IDLE;
      d.sda_oe  = 1'b0;
    end else begin
      case (q.st)
        tpir_pkg::TPIR_ADDR: begin
          if (scl_rise) begin
            d.shift   = {q.shift[6:0], q.sda_s2};
            d.bit_cnt = q.bit_cnt + 4'h1;
          end else if (addr_done) begin
            d.bit_cnt = 4'h0;
            if (q.shift[7:1] == tpir_pkg::DEV_ADDR) begin
              d.st      = tpir_pkg::TPIR_ADDR_ACK;
              d.sda_oe  = 1'b1;
              d.rw_read = (q.shift[0] == tpir_pkg::ADDR_BYTE_READ[0]);
            end else begin
              d.st      = tpir_pkg::TPIR_IDLE;
            end
          end
        end
        tpir_pkg::TPIR_ADDR_ACK: begin
          if (scl_fall) begin
            if (q.rw_read) begin
              d.st      = tpir_pkg::TPIR_TX;
              d.shift   = rd_byte;
              d.sda_oe  = ~rd_byte[7];
              d.index   = q.index + 8'h01;
              evt_clr   = (q.index == tpir_pkg::IDX_EVT);
            end else begin
              d.st      = tpir_pkg::TPIR_RX;
              d.sda_oe  = 1'b0;
              d.first   = 1'b1;
            end
          end
        end
        tpir_pkg::TPIR_RX: begin
          if (scl_rise) begin
            d.shift   = {q.shift[6:0], q.sda_s2};
            d.bit_cnt = q.bit_cnt + 4'h1;
          end else if (rx_done) begin
            d.st      = tpir_pkg::TPIR_RX_ACK;
            d.sda_oe  = 1'b1;
            d.bit_cnt = 4'h0;
            if (q.first) begin
              d.index = q.shift;
              d.first = 1'b0;
            end else begin
              if (q.index == tpir_pkg::IDX_CFG) begin
                d.cfg = q.shift;
              end
              d.index = q.index + 8'h01;
            end
          end
        end
        tpir_pkg::TPIR_RX_ACK: begin
          if (scl_fall) begin
            d.st     = tpir_pkg::TPIR_RX;
            d.sda_oe = 1'b0;
          end
        end
        tpir_pkg::TPIR_TX: begin
          if (scl_fall) begin
            if (q.bit_cnt == 4'h7) begin
              d.st      = tpir_pkg::TPIR_TX_ACK;
              d.sda_oe  = 1'b0;
              d.bit_cnt = 4'h0;
            end else begin
              d.bit_cnt = q.bit_cnt + 4'h1;
              d.shift   = {q.shift[6:0], 1'b0};
              d.sda_oe  = ~q.shift[6];
            end
          end
        end
        tpir_pkg::TPIR_TX_ACK: begin
          if (scl_rise) begin
            d.nack = q.sda_s2;
          end else if (scl_fall) begin
            if (q.nack) begin
              d.st      = tpir_pkg::TPIR_IDLE;
            end else begin
              d.st      = tpir_pkg::TPIR_TX;
              d.shift   = rd_byte;
              d.sda_oe  = ~rd_byte[7];
              d.index   = q.index + 8'h01;
              evt_clr   = (q.index == tpir_pkg::IDX_EVT);
            end
          end
        end
        default: begin
          d.sda_oe = 1'b0;
        end
      endcase
    end
    // pen tracking runs only while scanning is enabled
    if (q.pen_down && q.cfg[tpir_pkg::CFG_SCAN_BIT]) begin
      if (q.rep_cnt == REP_LAST) begin
        d.rep_cnt = '0;
        new_evt   = tpir_pkg::EVT_REPEAT;
      end else begin
        d.rep_cnt = q.rep_cnt + 1'b1;
      end
    end
    if (meas_take) begin
      if (press) begin
        d.x = meas.x;
        d.y = meas.y;
        if (!q.pen_down) begin
          d.pen_down = 1'b1;
          d.rep_cnt  = '0;
          new_evt    = tpir_pkg::EVT_DOWN;
        end
      end else if (q.pen_down) begin
        d.pen_down = 1'b0;
        new_evt    = tpir_pkg::EVT_UP;
      end
    end
    // a new event wins over the clear caused by reading the event register
    if (new_evt != tpir_pkg::EVT_NONE) begin
      d.evt = new_evt;
    end else if (evt_clr) begin
      d.evt = tpir_pkg::EVT_NONE;
    end
    if (srst) begin
      d          = '0;
      d.st       = tpir_pkg::TPIR_IDLE;
      d.scl_s1   = 1'b1;
      d.scl_s2   = 1'b1;
      d.scl_s3   = 1'b1;
      d.sda_s1   = 1'b1;
      d.sda_s2   = 1'b1;
      d.sda_s3   = 1'b1;
      d.cfg      = tpir_pkg::CFG_RESET;
      d.evt      = tpir_pkg::EVT_NONE;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign sda_o   = 1'b0;
  assign sda_oe  = q.sda_oe;
  assign scan_en = q.cfg[tpir_pkg::CFG_SCAN_BIT];
  assign irq     = (q.evt != tpir_pkg::EVT_NONE);

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_cfg_after_reset: assert property ($past(srst) |-> scan_en && q.evt == 4'h0)
    else $error("config or event not at reset value");
  a_addr_mismatch: assert property (addr_done && q.shift[7:1] != 7'h51 |=> !sda_oe)
    else $error("acknowledged a foreign address");
  a_read_decode: assert property (addr_done && q.shift == 8'hA2 |=> q.rw_read && sda_oe)
    else $error("0xA2 not taken as a read");
  a_write_decode: assert property (addr_done && q.shift == 8'hA3 |=> !q.rw_read && sda_oe)
    else $error("0xA3 not taken as a write");
  a_cfg_write: assert property (rx_done && !q.first && q.index == 8'h00
                                |=> q.cfg == $past(q.shift))
    else $error("config write lost");
  a_ro_ignored: assert property (rx_done && q.index != 8'h00 |=> $stable(q.cfg))
    else $error("read-only write changed config");
  a_index_set: assert property (rx_done && q.first |=> q.index == $past(q.shift))
    else $error("index byte not stored");
  a_down_event: assert property (meas_take && press && !q.pen_down
                                 |=> irq && q.evt == 4'h1 && q.x == $past(meas.x))
    else $error("pen-down not reported");
  a_no_press: assert property (meas.valid && !press |=> $stable(q.x) && $stable(q.y))
    else $error("coordinates taken from no-press sample");
  a_up_event: assert property (meas_take && !press && q.pen_down |=> q.evt == 4'h3)
    else $error("pen-up not reported");
  a_repeat_bound: assert property (q.pen_down |-> q.rep_cnt <= REP_LAST)
    else $error("repeat counter overran its period");
  a_hi_zero: assert property (((q.st == tpir_pkg::TPIR_ADDR_ACK && q.rw_read)
                               || (q.st == tpir_pkg::TPIR_TX_ACK && !q.nack)) && scl_fall
                              && (q.index == 8'h09 || q.index == 8'h0B)
                              |=> q.shift[7:2] == 6'h00)
    else $error("unused high bits not zero");
  a_tx_first_bit: assert property (q.st == tpir_pkg::TPIR_ADDR_ACK && scl_fall && q.rw_read
                                   |=> q.st == tpir_pkg::TPIR_TX && sda_oe == !$past(rd_byte[7]))
    else $error("first read bit not driven from the register");
  a_nack_end: assert property (q.st == tpir_pkg::TPIR_TX_ACK && scl_fall && q.nack
                               |=> q.st == tpir_pkg::TPIR_IDLE && !sda_oe)
    else $error("read not ended by master nack");
  a_idle_release: assert property (q.st == tpir_pkg::TPIR_IDLE |-> !sda_oe)
    else $error("data line held while idle");

  // pen event checks
  a_repeat_event: assert property (q.pen_down && scan_en && q.rep_cnt == REP_LAST
                                   && !meas.valid |=> q.evt == 4'h2 && irq)
    else $error("pen-down repeat not reported");
  a_evt_clear: assert property (evt_clr && new_evt == 4'h0 |=> q.evt == 4'h0 && !irq)
    else $error("event not cleared by its read");
  a_halt_frozen: assert property (!scan_en |=> $stable(q.x) && $stable(q.y)
                                  && $stable(q.pen_down) && $stable(q.rep_cnt))
    else $error("state moved while scanning halted");
  a_evt_code: assert property (q.evt <= 4'h3)
    else $error("event code outside its set");

  // main scenarios
  c_write_cfg: cover property (rx_done && !q.first && q.index == 8'h00);
  c_read_evt: cover property (evt_clr && q.evt != 4'h0);
  c_repeat: cover property (q.evt == 4'h2);
  c_pen_up: cover property (meas_take && !press && q.pen_down);
  c_burst: cover property (q.st == tpir_pkg::TPIR_TX_ACK && scl_fall && !q.nack);
endmodule // tpir_regs
